// ==== src/dmamc_top.sv ====
`timescale 1ns/1ns
// ============================================================
// Four channel DMA mode control registers behind AHB-Lite
//
// Notes on behaviour
// [RULE1] Auto request starts once run enable set
// [RULE2] Other sources start on requests after enabling
// [RULE3] Writing run enable 0 stops transfer
// [RULE4] Block mode stop waits for block end
// [RULE5] External halt clears run enable itself
// [RULE6] Software keeps mode fixed while running
// [RULE7] Run enable 1 means channel operating
// [RULE8] Total size reached clears run enable
// [RULE9] Repeat overflow halt clears run enable
// [RULE10] Size error halt clears run enable
// [RULE11] Address error or NMI clears run enable
// [RULE12] Reset and standby hold run enable 0
// [RULE13] Flags clear by 0 after read 1
// [RULE14] Per-channel register, run at 31, reset 0
// [RULE15] Bit 23 shows channel busy, read only
// [RULE16] Fault flag blocks all run enable writes
module dmamc_top (
  // Clock, reset and power state
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hw_standby,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Transfer requests
  input wire logic [dmamc_pkg::NUM_CH-1:0] periph_req,
  input wire logic [dmamc_pkg::NUM_CH-1:0] ext_req,
  // Datapath events and system faults
  input dmamc_pkg::dmamc_evt_t [dmamc_pkg::NUM_CH-1:0] chan_evt,
  input wire logic addr_err,
  input wire logic nmi,
  // Channel control out
  output logic [dmamc_pkg::NUM_CH-1:0] xfer_go,
  output logic [dmamc_pkg::NUM_CH-1:0] run_enable,
  output logic [dmamc_pkg::NUM_CH-1:0] chan_busy,
  // Interrupt
  output logic irq
);
  import dmamc_pkg::*;

  // ==========================================================
  // Storage
  logic [31:0] cfg_q [NUM_CH]; // Stored configuration bits
  logic [NUM_CH-1:0] run_q; // Channel run enable
  logic [NUM_CH-1:0] pend_q; // Block mode stop waiting for block end
  logic [NUM_CH-1:0] transfer_end_flag_q; // Transfer end flag
  logic [NUM_CH-1:0] extended_repeat_overflow_flag_q; // Extended repeat overflow flag
  logic [NUM_CH-1:0] transfer_end_flag_arm_q; // Transfer end flag read as 1
  logic [NUM_CH-1:0] extended_repeat_overflow_flag_arm_q; // Overflow flag read as 1
  logic fault_q; // System fault flag
  logic fault_arm_q; // System fault flag read as 1
  logic [STAT_W-1:0] stat_q; // Sticky event status
  logic [STAT_W-1:0] mask_q; // Interrupt mask
  logic [STAT_W-1:0] stat_set; // Events of this cycle
  logic irq_q; // Registered interrupt level
  logic [NUM_CH-1:0] busy; // From the sequencers
  logic [NUM_CH-1:0] clr_run; // Auto clear from the sequencers
  logic fault_evt; // Address error or NMI this cycle

  // Bus pipeline
  logic ap_take; // Address phase accepted
  logic rd_take; // Read accepted
  logic [2:0] ap_idx; // Word index of the address phase
  logic ap_map; // Address phase hits a register
  logic wr_q; // Write data phase pending
  logic [2:0] widx_q; // Word index of that write

  // ==========================================================
  // Helper functions

  // Register word index of a byte address, 3'h7 when unmapped
  function automatic logic [2:0] word_idx(input logic [31:0] a);
    logic [2:0] r;
    r = 3'h7;
    if (a == {24'h000000, OFS_MODE0}) r = 3'h0;
    if (a == {24'h000000, OFS_MODE1}) r = 3'h1;
    if (a == {24'h000000, OFS_MODE2}) r = 3'h2;
    if (a == {24'h000000, OFS_MODE3}) r = 3'h3;
    if (a == {24'h000000, OFS_STAT}) r = 3'h4;
    if (a == {24'h000000, OFS_MASK}) r = 3'h5;
    return r;
  endfunction : word_idx

  // Flag update where a hardware set beats a software clear
  function automatic logic flag_nxt(input logic f, input logic set,
                                    input logic clr);
    return set | (f & ~clr);
  endfunction : flag_nxt

  // Read-as-1 arming: a read of 1 arms, any write consumes it
  function automatic logic arm_nxt(input logic arm, input logic rd,
                                   input logic f, input logic wr);
    logic r;
    r = arm;
    if (wr) r = 1'b0;
    if (rd && f) r = 1'b1;
    return r;
  endfunction : arm_nxt

  // Readback word of one mode control register
  function automatic logic [31:0] mode_word(input logic [31:0] cfg,
      input logic run, input logic bsy, input logic flt,
      input logic es, input logic dt);
    logic [31:0] w;
    w = cfg & CFG_MASK;
    w[BIT_RUN] = run;
    w[BIT_BUSY] = bsy;
    w[BIT_FAULT] = flt;
    w[BIT_EXTENDED_REPEAT_OVERFLOW_FLAG] = es;
    w[BIT_TRANSFER_END_FLAG] = dt;
    return w;
  endfunction : mode_word

  // ==========================================================
  // AHB-Lite slave: no wait states, always OKAY
  assign ap_take = hsel & htrans[1] & hready;
  assign rd_take = ap_take & ~hwrite;
  assign ap_idx = word_idx(haddr);
  assign ap_map = (ap_idx != 3'h7);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Write address captured for the data phase; size is not
  // checked since only whole words are ever used
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wr_q <= 1'b0;
      widx_q <= 3'h7;
    end else begin
      wr_q <= ap_take & hwrite & ap_map;
      widx_q <= ap_idx;
    end
  end

  // Read data is sampled at the address phase so it stands in
  // the data phase; unmapped addresses read as zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      if (ap_idx < 3'(NUM_CH)) begin
        hrdata <= mode_word(cfg_q[ap_idx[1:0]], run_q[ap_idx[1:0]],
                            busy[ap_idx[1:0]],
                            (ap_idx == 3'h0) & fault_q, // [RULE16]
                            extended_repeat_overflow_flag_q[ap_idx[1:0]], transfer_end_flag_q[ap_idx[1:0]]);
      end else if (ap_idx == 3'h4) begin
        hrdata <= {{(32-STAT_W){1'b0}}, stat_q};
      end else if (ap_idx == 3'h5) begin
        hrdata <= {{(32-STAT_W){1'b0}}, mask_q};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Stored configuration bits; reserved and read-only bits are
  // masked off, so reserved bits always read as zero
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst) begin
        cfg_q[c] <= MODE_RST; // [RULE14]
      end else if (wr_q && widx_q == 3'(c)) begin
        cfg_q[c] <= hwdata & CFG_MASK; // [RULE6]
      end
    end
  end

  // ==========================================================
  // Run enable and deferred block stop
  assign fault_evt = addr_err | nmi;

  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst || hw_standby) begin
        // Standby holds the bit down as long as it lasts
        run_q[c] <= 1'b0; // [RULE12]
        pend_q[c] <= 1'b0;
      end else if (fault_evt) begin
        run_q[c] <= 1'b0; // [RULE11]
        pend_q[c] <= 1'b0;
      end else if (clr_run[c]) begin
        run_q[c] <= 1'b0; // [RULE5] [RULE8]
        pend_q[c] <= 1'b0;
      end else if (wr_q && widx_q == 3'(c) && !fault_q) begin // [RULE16]
        if (hwdata[BIT_RUN]) begin
          run_q[c] <= 1'b1; // [RULE1] [RULE7]
          pend_q[c] <= 1'b0;
        end else if (cfg_q[c][MODE_HI:MODE_LO] == MODE_BLOCK
                     && busy[c]) begin
          pend_q[c] <= 1'b1; // [RULE4]
        end else begin
          run_q[c] <= 1'b0; // [RULE3]
          pend_q[c] <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Clearable flags: cleared only by a 0 written after a 1 was
  // read; a fresh event in the same cycle still wins
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (rst) begin
        transfer_end_flag_q[c] <= 1'b0;
        extended_repeat_overflow_flag_q[c] <= 1'b0;
        transfer_end_flag_arm_q[c] <= 1'b0;
        extended_repeat_overflow_flag_arm_q[c] <= 1'b0;
      end else begin
        transfer_end_flag_q[c] <= flag_nxt(transfer_end_flag_q[c],
          chan_evt[c].total_end | chan_evt[c].size_err,
          wr_q && widx_q == 3'(c) && transfer_end_flag_arm_q[c]
          && !hwdata[BIT_TRANSFER_END_FLAG]); // [RULE13]
        extended_repeat_overflow_flag_q[c] <= flag_nxt(extended_repeat_overflow_flag_q[c],
          chan_evt[c].rpt_ovf | chan_evt[c].ext_rpt_ovf,
          wr_q && widx_q == 3'(c) && extended_repeat_overflow_flag_arm_q[c]
          && !hwdata[BIT_EXTENDED_REPEAT_OVERFLOW_FLAG]); // [RULE13]
        transfer_end_flag_arm_q[c] <= arm_nxt(transfer_end_flag_arm_q[c],
          rd_take && ap_idx == 3'(c), transfer_end_flag_q[c],
          wr_q && widx_q == 3'(c));
        extended_repeat_overflow_flag_arm_q[c] <= arm_nxt(extended_repeat_overflow_flag_arm_q[c],
          rd_take && ap_idx == 3'(c), extended_repeat_overflow_flag_q[c],
          wr_q && widx_q == 3'(c));
      end
    end
  end

  // System fault flag, present in channel 0 only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_q <= 1'b0;
      fault_arm_q <= 1'b0;
    end else begin
      fault_q <= flag_nxt(fault_q, fault_evt,
        wr_q && widx_q == 3'h0 && fault_arm_q
        && !hwdata[BIT_FAULT]); // [RULE13] [RULE16]
      fault_arm_q <= arm_nxt(fault_arm_q, rd_take && ap_idx == 3'h0,
                             fault_q, wr_q && widx_q == 3'h0);
    end
  end

  // ==========================================================
  // Interrupt status, mask and output
  always_comb begin
    stat_set = STAT_RST;
    for (int c = 0; c < NUM_CH; c++) begin
      stat_set[ST_END_LSB+c] = chan_evt[c].total_end;
      stat_set[ST_OVF_LSB+c] = chan_evt[c].rpt_ovf
                               | chan_evt[c].ext_rpt_ovf;
      stat_set[ST_SERR_LSB+c] = chan_evt[c].size_err;
    end
    stat_set[ST_FAULT] = fault_evt;
  end

  // A read clears the status, but events of that cycle survive
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q <= STAT_RST;
    end else if (rd_take && ap_idx == 3'h4) begin
      stat_q <= stat_set;
    end else begin
      stat_q <= stat_q | stat_set;
    end
  end

  // Mask register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_q <= STAT_RST;
    end else if (wr_q && widx_q == 3'h5) begin
      mask_q <= hwdata[STAT_W-1:0];
    end
  end

  // Registered so the pin never glitches; lags status by a cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end
  assign irq = irq_q;

  // ==========================================================
  // Channel sequencers
  for (genvar g = 0; g < NUM_CH; g++) begin : g_chan
    dmamc_chan u_chan (
      .sys_clk (sys_clk),
      .rst (rst),
      .run (run_q[g]),
      .src (cfg_q[g][SRC_HI:SRC_LO]),
      .blk_mode (cfg_q[g][MODE_HI:MODE_LO] == MODE_BLOCK),
      .stop_pend (pend_q[g]),
      .periph_req (periph_req[g]),
      .ext_req (ext_req[g]),
      .evt (chan_evt[g]),
      .busy (busy[g]),
      .go (xfer_go[g]),
      .clr_run (clr_run[g])
    );
  end

  assign run_enable = run_q; // [RULE7]
  assign chan_busy = busy; // [RULE15]

endmodule : dmamc_top

// ==== src/dmamc_pkg.sv ====
// ============================================================
// Shared constants and types of the DMA mode control block
package dmamc_pkg;

  // ==========================================================
  // Channel count and register map (word offsets in bytes)
  localparam int NUM_CH = 4;
  localparam logic [7:0] OFS_MODE0 = 8'h00; // Channel 0 mode control
  localparam logic [7:0] OFS_MODE1 = 8'h04; // Channel 1 mode control
  localparam logic [7:0] OFS_MODE2 = 8'h08; // Channel 2 mode control
  localparam logic [7:0] OFS_MODE3 = 8'h0c; // Channel 3 mode control
  localparam logic [7:0] OFS_STAT = 8'h10; // Event status, read clears
  localparam logic [7:0] OFS_MASK = 8'h14; // Interrupt mask
  localparam logic [31:0] MODE_RST = 32'h0000_0000; // Value after reset

  // ==========================================================
  // Mode control field layout
  localparam int BIT_RUN = 31; // Channel run enable
  localparam int BIT_BUSY = 23; // Channel busy indicator
  localparam int BIT_FAULT = 19; // System fault flag, channel 0 only
  localparam int BIT_EXTENDED_REPEAT_OVERFLOW_FLAG = 17; // Extended repeat overflow flag
  localparam int BIT_TRANSFER_END_FLAG = 16; // Transfer end flag
  localparam int MODE_HI = 13; // Transfer mode field
  localparam int MODE_LO = 12;
  localparam int SRC_HI = 7; // Request source field
  localparam int SRC_LO = 6;
  // Bits that software stores; run enable is kept apart
  localparam logic [31:0] CFG_MASK = 32'h7c00_fbe7;

  // ==========================================================
  // Field encodings
  localparam logic [1:0] SRC_AUTO = 2'h0; // Auto request
  localparam logic [1:0] SRC_EXT = 2'h1; // External request pin
  localparam logic [1:0] SRC_PERIPH = 2'h2; // Peripheral interrupt
  localparam logic [1:0] MODE_BLOCK = 2'h2; // Block transfer mode

  // ==========================================================
  // Event status layout
  localparam int STAT_W = 13;
  localparam int ST_END_LSB = 0; // Total size reached, per channel
  localparam int ST_OVF_LSB = 4; // Repeat overflow, per channel
  localparam int ST_SERR_LSB = 8; // Size error, per channel
  localparam int ST_FAULT = 12; // Address error or NMI
  localparam logic [STAT_W-1:0] STAT_RST = 13'h0000;

  // ==========================================================
  // Channel sequencer states
  typedef enum logic [1:0] {
    CH_IDLE = 2'b00, // Run enable off
    CH_WAIT = 2'b01, // Enabled, waiting for a request
    CH_ACT = 2'b10 // Transfer in flight
  } dmamc_state_t;

  // Events reported by the transfer datapath, one set per channel
  typedef struct packed {
    logic unit_ack; // One access unit completed
    logic block_end; // Last unit of a block completed
    logic total_end; // Programmed total size reached
    logic rpt_ovf; // Halt by repeat size end overflow
    logic ext_rpt_ovf; // Halt by extended repeat size end overflow
    logic size_err; // Halt by transfer size error
  } dmamc_evt_t;

endpackage : dmamc_pkg

// ==== src/dmamc_chan.sv ====
`timescale 1ns/1ns
// ============================================================
// One channel sequencer: start, stop and auto clear of a run
module dmamc_chan (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Control from the register file
  input wire logic run,
  input wire logic [1:0] src,
  input wire logic blk_mode,
  input wire logic stop_pend,
  // Request inputs
  input wire logic periph_req,
  input wire logic ext_req,
  input dmamc_pkg::dmamc_evt_t evt,
  // Status and strobes
  output logic busy,
  output logic go,
  output logic clr_run
);
  import dmamc_pkg::*;

  dmamc_state_t state_q; // Sequencer state
  dmamc_state_t state_d;
  logic req_prev_q; // Last sample of the selected request
  logic sel_req; // Request line picked by the source field
  logic new_req; // Request edge seen this cycle

  // Only a request that rises after enabling may start a run;
  // a level left high from before is not counted
  assign sel_req = (src == SRC_EXT) ? ext_req : periph_req;
  assign new_req = sel_req & ~req_prev_q; // [RULE2]

  // Halt causes that take the run enable away
  assign clr_run = run & (evt.total_end // [RULE8]
                   | evt.rpt_ovf | evt.ext_rpt_ovf // [RULE9]
                   | evt.size_err // [RULE10]
                   | (stop_pend & evt.block_end)); // [RULE4]

  // Request edge history
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_prev_q <= 1'b0;
    end else begin
      req_prev_q <= sel_req;
    end
  end

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CH_IDLE: begin
        if (run) begin
          state_d = CH_WAIT;
        end
      end
      CH_WAIT: begin
        if (!run) begin
          state_d = CH_IDLE;
        end else if (src == SRC_AUTO) begin
          state_d = CH_ACT; // [RULE1]
        end else if ((src == SRC_EXT || src == SRC_PERIPH) && new_req) begin
          state_d = CH_ACT; // [RULE2]
        end
      end
      CH_ACT: begin
        if (!run || clr_run) begin
          state_d = CH_IDLE; // [RULE3] [RULE5]
        end else if (evt.unit_ack && !(blk_mode && !evt.block_end)) begin
          state_d = CH_WAIT; // A block runs on without new requests
        end
      end
      default: state_d = CH_IDLE; // Two-bit code 2'b11 is illegal
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= CH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign busy = (state_q == CH_ACT); // [RULE15]
  assign go = (state_q == CH_ACT) & run; // [RULE7]

endmodule : dmamc_chan

// ==== bench/dmamc_monitor.sv ====
`timescale 1ns/1ns
// ====
// Port checker of the DMA mode control block
module dmamc_monitor (
  // Clock, reset and power state
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hw_standby,
  // Bus answer
  input logic hreadyout,
  input logic hresp,
  // Events and faults
  input dmamc_pkg::dmamc_evt_t [dmamc_pkg::NUM_CH-1:0] chan_evt,
  input wire logic addr_err,
  input wire logic nmi,
  // Channel control
  input logic [dmamc_pkg::NUM_CH-1:0] xfer_go,
  input logic [dmamc_pkg::NUM_CH-1:0] run_enable,
  input logic [dmamc_pkg::NUM_CH-1:0] chan_busy,
  input logic irq
);
  import dmamc_pkg::*;
  logic [NUM_CH-1:0] fin; // Total size reached
  logic [NUM_CH-1:0] ovf; // Either repeat overflow
  logic [NUM_CH-1:0] serr; // Size error
  // Halt causes gathered per channel
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      fin[c] = chan_evt[c].total_end;
      ovf[c] = chan_evt[c].rpt_ovf | chan_evt[c].ext_rpt_ovf;
      serr[c] = chan_evt[c].size_err;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Fault pulse, then two quiet cycles on every channel
  sequence s_fault; addr_err || nmi; endsequence
  sequence s_all_off; (run_enable == 4'h0 && xfer_go == 4'h0) [*2]; endsequence
  property p_bus_okay; hreadyout && !hresp; endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus answer");
  property p_reset_clear;
    disable iff (1'b0) rst |=> (run_enable == 4'h0 && !irq);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset left a channel on");
  property p_standby; hw_standby |=> run_enable == 4'h0; endproperty
  a_standby: assert property (p_standby)
    else $error("standby left a channel on");
  property p_fault; s_fault |=> s_all_off; endproperty
  a_fault: assert property (p_fault)
    else $error("fault did not stop channels");
  property p_total; fin != 4'h0 |=> (run_enable & $past(fin)) == 4'h0;
  endproperty
  a_total: assert property (p_total)
    else $error("run kept after total end");
  property p_ovf; ovf != 4'h0 |=> (run_enable & $past(ovf)) == 4'h0;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("run kept after overflow");
  property p_serr; serr != 4'h0 |=> (run_enable & $past(serr)) == 4'h0;
  endproperty
  a_serr: assert property (p_serr)
    else $error("run kept after size error");
  property p_go_run; (xfer_go & ~(run_enable & chan_busy)) == 4'h0;
  endproperty
  a_go_run: assert property (p_go_run)
    else $error("transfer without run and busy");
  property p_go_late;
    (xfer_go & ~$past(xfer_go) & ~$past(run_enable)) == 4'h0;
  endproperty
  a_go_late: assert property (p_go_late)
    else $error("transfer began with run off");
  property p_busy_off;
    ($past(~run_enable) & ~run_enable & chan_busy) == 4'h0;
  endproperty
  a_busy_off: assert property (p_busy_off)
    else $error("busy while run off");
endmodule : dmamc_monitor

bind dmamc_top dmamc_monitor i_dmamc_monitor (.sys_clk, .rst, .hw_standby,
  .hreadyout, .hresp, .chan_evt, .addr_err, .nmi, .xfer_go, .run_enable,
  .chan_busy, .irq);

// ==== bench/dmamc_xfer_model.sv ====
`timescale 1ns/1ns
// ====
// Transfer datapath stand-in: answers an active cycle with a unit, then skips the next cycle
module dmamc_xfer_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Channel control seen from the block
  input wire logic [dmamc_pkg::NUM_CH-1:0] xfer_go,
  input wire logic [dmamc_pkg::NUM_CH-1:0] run_enable,
  // Pace, total units and halt cause chosen by the bench
  input wire logic slow,
  input wire logic [3:0] units,
  input wire logic [1:0] halt_kind,
  // Completion events
  output dmamc_pkg::dmamc_evt_t [dmamc_pkg::NUM_CH-1:0] chan_evt
);
  import dmamc_pkg::*;
  logic [3:0] cnt_q [NUM_CH]; // Units done per channel
  logic [1:0] pace_q; // Slow mode answers one cycle in four
  always_ff @(posedge sys_clk) begin
    pace_q <= rst ? 2'h0 : pace_q + 2'h1;
  end
  // Skip the cycle after an answer: the block leaves active state then, except mid block in block mode
  always_ff @(posedge sys_clk) begin
    for (int c = 0; c < NUM_CH; c++) begin
      chan_evt[c] <= '0;
      if (rst || !run_enable[c]) begin
        cnt_q[c] <= 4'h0;
      end else if (xfer_go[c] && !chan_evt[c].unit_ack &&
                   (!slow || pace_q == 2'h0)) begin
        cnt_q[c] <= cnt_q[c] + 4'h1;
        chan_evt[c].unit_ack <= 1'b1;
        chan_evt[c].block_end <= cnt_q[c][2:0] == 3'h7; // Eight per block
        if (cnt_q[c] == units - 4'h1) begin // Halt on last unit
          chan_evt[c].total_end <= halt_kind == 2'h0;
          chan_evt[c].rpt_ovf <= halt_kind == 2'h1;
          chan_evt[c].ext_rpt_ovf <= halt_kind == 2'h2;
          chan_evt[c].size_err <= halt_kind == 2'h3;
        end
      end
    end
  end
endmodule : dmamc_xfer_model

// ==== bench/dmamc_tb_top.sv ====
`timescale 1ns/1ns
// ====
// Self-checking bench of the DMA mode control block
module dmamc_tb_top;
  import dmamc_pkg::*;
  logic sys_clk = 1'b0, rst, hw_standby, hsel, hwrite, hready;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, halt_kind;
  logic [2:0] hsize;
  logic hreadyout, hresp, addr_err, nmi, irq, slow;
  logic [3:0] periph_req, ext_req, xfer_go, run_enable, chan_busy, units;
  dmamc_evt_t [NUM_CH-1:0] chan_evt;
  int seed = 69826, mismatches = 0, checks = 0, cyc = 0;
  always #20 sys_clk = ~sys_clk;
  assign hready = hreadyout; // Single slave drives the bus ready
  dmamc_top i_dmamc_top (.sys_clk, .rst, .hw_standby, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .periph_req, .ext_req, .chan_evt, .addr_err, .nmi, .xfer_go,
    .run_enable, .chan_busy, .irq);
  dmamc_xfer_model i_dmamc_xfer_model (.sys_clk, .rst, .xfer_go,
    .run_enable, .slow, .units, .halt_kind, .chan_evt);
  // ====
  // Checking and bus helpers
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Hold each phase until ready is seen high at an edge
  task automatic bus(logic [7:0] a, logic w, logic [31:0] d,
                     output logic [31:0] r);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : bus
  task automatic wr(logic [7:0] a, logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask : wr
  task automatic rd(logic [7:0] a, output logic [31:0] r);
    bus(a, 1'b0, 32'h0, r);
  endtask : rd
  function automatic logic [7:0] ofs(int c);
    return 8'(c * 4);
  endfunction : ofs
  function automatic logic pick(int s, int c);
    return s == 0 ? xfer_go[c] : s == 1 ? run_enable[c] : chan_busy[c];
  endfunction : pick
  // Bounded wait on go (0), run (1) or busy (2)
  task automatic wait_for(int s, int c, logic v);
    int n;
    n = 0;
    while (pick(s, c) !== v && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    chk("channel line", 32'(v), 32'(pick(s, c)));
  endtask : wait_for
  function automatic logic [31:0] flag_exp(int k);
    return (k == 1 || k == 2) ? 32'h0002_0000 : 32'h0001_0000;
  endfunction : flag_exp
  function automatic logic [31:0] stat_exp(int k, int c);
    return 32'h1 << (k == 0 ? c : k == 3 ? 8 + c : 4 + c);
  endfunction : stat_exp
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end
  // ====
  // Main sequence
  initial begin
    logic [31:0] r, d;
    int c;
    {rst, hsel, hsize, htrans, hwrite} <= {1'b1, 1'b1, 3'h2, 2'h0, 1'b0};
    {haddr, hwdata, hw_standby, addr_err, nmi} <= '0;
    {periph_req, ext_req, slow, units, halt_kind} <= '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    for (int k = 0; k < 7; k++) begin // Six registers, one unmapped word
      rd(ofs(k), r);
      chk("reset value", 32'h0, r);
    end
    for (int k = 0; k < 8; k++) begin // Random setups, run kept off
      d = $random(seed) & 32'h7fff_ffff;
      wr(ofs(k % 4), d);
      rd(ofs(k % 4), r);
      chk("mode field", d & CFG_MASK, r);
    end
    units <= 4'h3;
    for (int k = 0; k < 4; k++) begin // Auto start, each halt cause
      halt_kind <= k[1:0];
      wr(OFS_MASK, k % 2 == 0 ? 32'h1fff : 32'h0);
      wr(ofs(k), 32'h8000_0000);
      wait_for(0, k, 1'b1);
      wait_for(1, k, 1'b0);
      rd(ofs(k), r);
      chk("halt flags", flag_exp(k), r);
      chk("irq", 32'(k % 2 == 0), 32'(irq));
      rd(OFS_STAT, r);
      chk("status", stat_exp(k, k), r);
      rd(OFS_STAT, r);
      chk("status cleared", 32'h0, r);
      chk("irq off", 32'h0, 32'(irq));
      wr(ofs(k), 32'h0); // Write 0 after read 1 clears flags
      rd(ofs(k), r);
      chk("flags cleared", 32'h0, r);
    end
    {units, slow} <= {4'hf, 1'b1};
    for (int k = 0; k < 2; k++) begin // Peripheral then external source
      c = k + 1;
      d = k == 0 ? 32'h0000_0080 : 32'h0000_0040;
      {periph_req[c], ext_req[c]} <= k == 0 ? 2'b10 : 2'b01;
      wr(ofs(c), d | 32'h8000_0000);
      repeat (6) @(posedge sys_clk);
      chk("early start", 32'h0, 32'(xfer_go[c]));
      {periph_req, ext_req} <= '0;
      @(posedge sys_clk);
      {periph_req[c], ext_req[c]} <= k == 0 ? 2'b10 : 2'b01;
      wait_for(0, c, 1'b1);
      wr(ofs(c), d); // Source unchanged while running
      wait_for(2, c, 1'b0);
      chk("stopped", 32'h0, 32'(xfer_go[c]));
      wait_for(1, c, 1'b0);
    end
    wr(ofs(3), 32'h8000_2000); // Block mode, stop mid block
    wait_for(2, 3, 1'b1);
    wr(ofs(3), 32'h0000_2000);
    rd(ofs(3), r);
    chk("pending stop", 32'h8080_2000, r);
    chk("deferred run", 32'h1, 32'(run_enable[3]));
    wait_for(1, 3, 1'b0);
    rd(ofs(3), r);
    chk("after block", 32'h0000_2000, r);
    for (int k = 0; k < 2; k++) begin // Fault by NMI, then address error
      wr(ofs(1), 32'h8000_0000);
      wait_for(2, 1, 1'b1);
      {nmi, addr_err} <= k == 0 ? 2'b10 : 2'b01;
      @(posedge sys_clk);
      {nmi, addr_err} <= 2'b00;
      wait_for(1, 1, 1'b0);
      wr(ofs(2), 32'h8000_0000);
      rd(ofs(2), r);
      chk("blocked run", 32'h0, r);
      rd(ofs(0), r);
      chk("fault flag", 32'h0008_0000, r);
      wr(ofs(0), 32'h0008_0000); // A 1 does nothing but disarms
      wr(ofs(0), 32'h0);
      rd(ofs(0), r);
      chk("disarmed", 32'h0008_0000, r);
      wr(ofs(0), 32'h0);
      rd(ofs(0), r);
      chk("fault cleared", 32'h0, r);
      rd(OFS_STAT, r);
      chk("fault status", 32'h1000, r);
    end
    wr(ofs(3), 32'h8000_0000); // Standby drops a running channel
    wait_for(1, 3, 1'b1);
    hw_standby <= 1'b1;
    @(posedge sys_clk);
    hw_standby <= 1'b0;
    @(posedge sys_clk);
    chk("standby run", 32'h0, 32'(run_enable[3]));
    close_out();
  end
endmodule : dmamc_tb_top
